// ---- amplitude_scaler.v ----
`default_nettype none
// scales a signed library sample by the attenuation code
module amplitude_scaler (
    input  wire [7:0] sample_in,   // signed library sample
    input  wire [1:0] atten_in,    // attenuation code
    output reg  [7:0] scaled_out   // scaled sample
);
    wire signed [9:0] s1 = {{2{sample_in[7]}}, sample_in}; // sign extended sample
    reg  signed [9:0] acc;                                   // scaled sum

    // shifts and adds keep this free of a multiplier
    always @* begin
        case (atten_in)
            2'h0:    acc = s1;                       // full strength
            2'h1:    acc = (s1 >>> 1) + (s1 >>> 2);  // three quarters
            2'h2:    acc = s1 >>> 1;                 // half
            default: acc = s1 >>> 2;                 // one quarter
        endcase
        scaled_out = acc[7:0];
    end
endmodule
`default_nettype wire

// ---- haptic_defines.vh ----
`ifndef HAPTIC_DEFINES_VH
`define HAPTIC_DEFINES_VH
// register offsets
`define ADDR_LIBRARY_CONFIG     8'h0d
`define ADDR_REALTIME_AMPLITUDE 8'h0e
`define ADDR_SEQUENCE_SLOT_ONE  8'h0f
// reset values
`define RST_LIBRARY_CONFIG      8'h00
`define RST_REALTIME_AMPLITUDE  8'h7f
`define RST_SEQUENCE_SLOT_ONE   8'h01
// library_config field positions
`define BIT_LIBRARY_LOADED      7
`define BIT_LIBRARY_CHOICE      6
`define BIT_SAMPLE_PERIOD       5
`define MSB_RESERVED            4
`define LSB_RESERVED            2
`define MSB_ATTEN               1
`define LSB_ATTEN               0
// sequence slot fields
`define BIT_SLOT_IS_DELAY       7
// timing at 100 MHz
`define CLK_PERIOD_NS           10
`define STEP_SLOW_MS            5
`define STEP_FAST_MS            1
`define DELAY_UNIT_MS           10
`define STEP_SLOW_CYCLES        ((`STEP_SLOW_MS * 1000000) / `CLK_PERIOD_NS)
`define STEP_FAST_CYCLES        ((`STEP_FAST_MS * 1000000) / `CLK_PERIOD_NS)
`define DELAY_UNIT_CYCLES       ((`DELAY_UNIT_MS * 1000000) / `CLK_PERIOD_NS)
// playback modes
`define MODE_LIBRARY            2'h0
`define MODE_DIRECT             2'h1
`endif

// ---- haptic_playback_config_regs.v ----
`include "haptic_defines.vh"
`default_nettype none
module haptic_playback_config_regs #(
    parameter DELAY_UNIT = `DELAY_UNIT_CYCLES,  // cycles per 10 ms delay step
    parameter STEP_SLOW  = `STEP_SLOW_CYCLES,   // cycles per 5 ms sample
    parameter STEP_FAST  = `STEP_FAST_CYCLES    // cycles per 1 ms sample
) (
    input  wire       clk_sys_in,          // system clock, 100 MHz
    input  wire       rst_in,              // sync reset, high
    input  wire       ce_in,               // clock enable, freezes all state
    input  wire       wr_en_in,            // register write strobe
    input  wire [7:0] addr_in,             // register address
    input  wire [7:0] wr_data_in,          // write data
    output reg  [7:0] rd_data_out,         // registered read data
    input  wire [1:0] mode_in,             // playback mode selector
    input  wire       start_in,            // start level from control logic
    input  wire       ext_trigger_in,      // external trigger pin, async
    input  wire       library_ready_in,    // library has been chosen/loaded
    input  wire [7:0] library_sample_in,   // signed sample from library
    output wire       library_choice_out,  // 0 closed-loop, 1 open-loop
    output reg        sample_tick_out,     // one pulse per library step
    output reg        slot_fetch_out,      // pulse: fetch effect for slot one
    output wire [6:0] slot_effect_out,     // effect identifier to play
    input  wire       effect_done_in,      // library effect finished
    output reg  [7:0] drive_out,           // signed drive to output stage
    output reg        drive_valid_out,     // drive value is live
    output reg        busy_out             // process running (start bit)
);
    reg  [7:0] library_config_r;     // config register, bit 7 is loaded flag
    reg  [7:0] realtime_amplitude_r; // direct drive entry
    reg  [7:0] sequence_slot_one_r;  // first sequencer slot
    reg  [2:0] trig_sync_r;          // three-stage synchroniser
    reg        trig_level_r;         // agreed trigger level
    reg  [1:0] state_r;              // playback state
    reg  [1:0] state_nxt;            // next playback state
    reg  [31:0] step_count_r;        // sample step counter
    wire [7:0] scaled_sample;        // attenuated library sample
    wire       delay_busy;           // delay timer running
    wire       delay_done;           // delay timer expired
    wire       trig_rise;            // trigger rising edge
    wire       start_req;            // any start request
    wire       stop_req;             // start level cleared
    wire [31:0] step_limit;          // current step length
    wire [31:0] delay_cycles;        // slot delay length

    localparam ST_IDLE   = 2'h0;     // nothing running
    localparam ST_DIRECT = 2'h1;     // direct drive playback
    localparam ST_EFFECT = 2'h2;     // library effect from slot one
    localparam ST_DELAY  = 2'h3;     // slot is a timed wait

    wire [6:0] slot_value = sequence_slot_one_r[6:0];            // slot payload
    wire       slot_delay = sequence_slot_one_r[`BIT_SLOT_IS_DELAY]; // wait flag

    assign library_choice_out = library_config_r[`BIT_LIBRARY_CHOICE];
    assign slot_effect_out    = slot_value;
    // period select picks the step length
    assign step_limit = library_config_r[`BIT_SAMPLE_PERIOD] ?
                        STEP_FAST : STEP_SLOW;
    // 7-bit count times 10 ms
    assign delay_cycles = slot_value * DELAY_UNIT;
    assign trig_rise = trig_sync_r[2] & trig_sync_r[1] & ~trig_level_r;
    // trigger counts the same as a written start
    assign start_req = start_in | trig_rise;
    // clearing the start level ends playback at once, but only while the agreed trigger level is low
    assign stop_req  = ~start_in & ~trig_level_r;

    amplitude_scaler u_scaler (
        .sample_in  (library_sample_in),
        .atten_in   (library_config_r[`MSB_ATTEN:`LSB_ATTEN]),
        .scaled_out (scaled_sample)
    );

    interval_timer #(.WIDTH(32)) u_delay (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .start_in   (state_r != ST_DELAY && state_nxt == ST_DELAY),
        .stop_in    (state_r == ST_DELAY && stop_req),
        .cycles_in  (delay_cycles),
        .busy_out   (delay_busy),
        .done_out   (delay_done)
    );

    // trigger pin synchroniser: stage 0 feeds only stage 1
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            trig_sync_r  <= 3'h0;
            trig_level_r <= 1'b0;
        end else if (ce_in) begin
            trig_sync_r <= {trig_sync_r[1:0], ext_trigger_in};
            if (trig_sync_r[2] == trig_sync_r[1]) begin
                trig_level_r <= trig_sync_r[2];  // change counts once two agree
            end
        end
    end

    // register writes; loaded flag follows hardware only
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            library_config_r     <= `RST_LIBRARY_CONFIG;
            realtime_amplitude_r <= `RST_REALTIME_AMPLITUDE;
            sequence_slot_one_r  <= `RST_SEQUENCE_SLOT_ONE;
        end else if (ce_in) begin
            if (library_ready_in) begin
                library_config_r[`BIT_LIBRARY_LOADED] <= 1'b1;
            end
            if (wr_en_in) begin
                case (addr_in)
                    `ADDR_LIBRARY_CONFIG: begin
                        // bit 7 not writable; reserved bits stored as given
                        library_config_r[6:0] <= wr_data_in[6:0];
                    end
                    `ADDR_REALTIME_AMPLITUDE: begin
                        realtime_amplitude_r <= wr_data_in;
                    end
                    `ADDR_SEQUENCE_SLOT_ONE: begin
                        sequence_slot_one_r <= wr_data_in;
                    end
                    default: begin
                        // other addresses belong elsewhere
                    end
                endcase
            end
        end
    end

    // registered read; unmapped addresses read zero
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            rd_data_out <= 8'h00;
        end else if (ce_in) begin
            case (addr_in)
                `ADDR_LIBRARY_CONFIG:     rd_data_out <= library_config_r;
                `ADDR_REALTIME_AMPLITUDE: rd_data_out <= realtime_amplitude_r;
                `ADDR_SEQUENCE_SLOT_ONE:  rd_data_out <= sequence_slot_one_r;
                default:                  rd_data_out <= 8'h00;
            endcase
        end
    end

    // playback state choice
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_req) begin
                    if (mode_in == `MODE_DIRECT) begin
                        state_nxt = ST_DIRECT;
                    end else if (slot_value == 7'h00) begin
                        state_nxt = ST_IDLE;
                    end else if (slot_delay) begin
                        state_nxt = ST_DELAY;
                    end else begin
                        state_nxt = ST_EFFECT;
                    end
                end
            end
            ST_DIRECT: begin
                if (stop_req || mode_in != `MODE_DIRECT) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_EFFECT: begin
                if (stop_req || effect_done_in) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_DELAY: begin
                if (stop_req || delay_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // playback state, step ticks and drive output
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_r         <= ST_IDLE;
            step_count_r    <= 32'h0;
            sample_tick_out <= 1'b0;
            slot_fetch_out  <= 1'b0;
            drive_out       <= 8'h00;
            drive_valid_out <= 1'b0;
            busy_out        <= 1'b0;
        end else if (ce_in) begin
            state_r         <= state_nxt;
            sample_tick_out <= 1'b0;
            slot_fetch_out  <= (state_r == ST_IDLE) && (state_nxt == ST_EFFECT);
            busy_out        <= (state_nxt != ST_IDLE);
            case (state_r)
                ST_DIRECT: begin
                    // signed value passed straight, no attenuation, every cycle
                    drive_out       <= realtime_amplitude_r;
                    drive_valid_out <= (state_nxt == ST_DIRECT);
                end
                ST_EFFECT: begin
                    // library step timing; a long step length costs only a counter
                    if (step_count_r + 32'h1 >= step_limit) begin
                        step_count_r    <= 32'h0;
                        sample_tick_out <= 1'b1;
                        drive_out       <= scaled_sample;
                    end else begin
                        step_count_r <= step_count_r + 32'h1;
                    end
                    drive_valid_out <= (state_nxt == ST_EFFECT);
                end
                default: begin
                    // idle and delay hold the load at zero
                    step_count_r    <= 32'h0;
                    drive_out       <= 8'h00;
                    drive_valid_out <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- haptic_playback_config_regs_tb.sv ----
`include "haptic_defines.vh"
`default_nettype none
module haptic_playback_config_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DU = 10;         // short delay step for simulation
    localparam int SS = 5;          // short slow step
    localparam int SF = 1;          // short fast step
    logic       clk_sys_in = 1'b0;  // system clock
    logic       rst_in     = 1'b1;  // sync reset
    logic       ce_in      = 1'b1;  // clock enable
    logic       wr_en_in, slot_fetch_out, library_choice_out, sample_tick_out;
    logic [7:0] addr_in, wr_data_in, rd_data_out, drive_out;
    logic [1:0] mode_in    = 2'h0;  // playback mode
    logic       start_in   = 1'b0;  // start level
    logic       trig_in    = 1'b0;  // trigger pin
    logic       ready_in   = 1'b0;  // library loaded
    logic [7:0] sample_in  = 8'hc3; // odd negative sample, tests truncation
    logic [6:0] slot_effect_out;    // effect id
    logic       drive_valid_out, busy_out;
    int         n_errors = 0;       // mismatches
    int         checks_done = 0;    // comparisons
    always #5 clk_sys_in = ~clk_sys_in;
    haptic_playback_config_regs #(.DELAY_UNIT(DU), .STEP_SLOW(SS), .STEP_FAST(SF)) i_dut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in), .wr_en_in(wr_en_in),
        .addr_in(addr_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
        .mode_in(mode_in), .start_in(start_in), .ext_trigger_in(trig_in),
        .library_ready_in(ready_in), .library_sample_in(sample_in),
        .library_choice_out(library_choice_out), .sample_tick_out(sample_tick_out),
        .slot_fetch_out(slot_fetch_out), .slot_effect_out(slot_effect_out),
        .effect_done_in(1'b0), .drive_out(drive_out), .drive_valid_out(drive_valid_out),
        .busy_out(busy_out));
    host_model i_host (.clk_sys_in(clk_sys_in), .rd_data_in(rd_data_out),
        .wr_en_out(wr_en_in), .addr_out(addr_in), .wr_data_out(wr_data_in));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.read(a, d);
        check("register read", exp, d);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    // bounded wait for the busy level, then compare it
    task automatic wait_busy(input logic lvl);
        for (int n = 0; n < 200 && busy_out !== lvl; n++) step(1);
        check("busy", {7'h0, lvl}, {7'h0, busy_out});
    endtask
    // attenuation worked out with arithmetic shifts
    function automatic logic [7:0] scale(input logic signed [7:0] s, input logic [1:0] a);
        case (a)
            2'h0: return s;
            2'h1: return (s >>> 1) + (s >>> 2);
            2'h2: return s >>> 1;
            default: return s >>> 2;
        endcase
    endfunction
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog: the tests need well under a tenth of this
    initial begin
        #50000;
        n_errors++;
        $display("Error watchdog expected finish seen hang");
        end_sim();
    end
    initial begin
        logic [7:0] amps [3];
        int gap;
        amps = '{8'h80, 8'h7f, 8'hff};
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rd_chk(`ADDR_LIBRARY_CONFIG, `RST_LIBRARY_CONFIG);
        rd_chk(`ADDR_REALTIME_AMPLITUDE, `RST_REALTIME_AMPLITUDE);
        rd_chk(`ADDR_SEQUENCE_SLOT_ONE, `RST_SEQUENCE_SLOT_ONE);
        i_host.write(8'h20, 8'h55);
        rd_chk(8'h20, 8'h00);
        // reserved bits written as zero, loaded bit written high must not stick
        i_host.write(`ADDR_LIBRARY_CONFIG, 8'he3);
        rd_chk(`ADDR_LIBRARY_CONFIG, 8'h63);
        check("choice", 8'h01, {7'h0, library_choice_out});
        ready_in <= 1'b1;
        step(1);
        ready_in <= 1'b0;
        i_host.write(`ADDR_LIBRARY_CONFIG, 8'h00);
        rd_chk(`ADDR_LIBRARY_CONFIG, 8'h80);
        check("choice", 8'h00, {7'h0, library_choice_out});
        // a write while the clock enable is low must be lost
        ce_in <= 1'b0;
        i_host.write(`ADDR_REALTIME_AMPLITUDE, 8'h11);
        ce_in <= 1'b1;
        rd_chk(`ADDR_REALTIME_AMPLITUDE, `RST_REALTIME_AMPLITUDE);
        $display("registers test done");
        // direct drive with quarter attenuation set, which must be ignored
        i_host.write(`ADDR_LIBRARY_CONFIG, 8'h03);
        mode_in <= `MODE_DIRECT;
        start_in <= 1'b1;
        wait_busy(1'b1);
        foreach (amps[i]) begin
            i_host.write(`ADDR_REALTIME_AMPLITUDE, amps[i]);
            step(4);
            check("drive", amps[i], drive_out);
        end
        start_in <= 1'b0;
        wait_busy(1'b0);
        step(2);
        check("drive valid", 8'h00, {7'h0, drive_valid_out});
        $display("direct drive test done");
        // library playback: every code, step period alternating
        mode_in <= `MODE_LIBRARY;
        i_host.write(`ADDR_SEQUENCE_SLOT_ONE, 8'h05);
        for (int a = 0; a < 4; a++) begin
            i_host.write(`ADDR_LIBRARY_CONFIG, {2'b0, a[0], 3'b0, a[1:0]});
            start_in <= 1'b1;
            wait_busy(1'b1);
            for (int n = 0; n < 50 && sample_tick_out !== 1'b1; n++) step(1);
            gap = 0;
            do begin
                step(1);
                gap++;
            end while (sample_tick_out !== 1'b1 && gap < 50);
            check("step gap", 8'(a[0] ? SF : SS), gap[7:0]);
            check("scaled drive", scale(sample_in, a[1:0]), drive_out);
            start_in <= 1'b0;
            wait_busy(1'b0);
        end
        $display("attenuation test done");
        // stop identifier refuses to start
        i_host.write(`ADDR_SEQUENCE_SLOT_ONE, 8'h00);
        start_in <= 1'b1;
        step(5);
        check("busy on stop id", 8'h00, {7'h0, busy_out});
        start_in <= 1'b0;
        // delay slot of three steps, started by the trigger pin
        i_host.write(`ADDR_SEQUENCE_SLOT_ONE, 8'h83);
        trig_in <= 1'b1;
        wait_busy(1'b1);
        gap = 0;
        while (busy_out === 1'b1 && gap < 200) begin
            step(1);
            gap++;
        end
        check("delay span", 8'h01, {7'h0, gap >= 3 * DU - 1 && gap <= 3 * DU + 3});
        trig_in <= 1'b0;
        $display("sequencer test done");
        end_sim();
    end
endmodule
`default_nettype wire

// ---- haptic_playback_monitor.sv ----
`default_nettype none
module haptic_playback_monitor #(
    parameter DELAY_UNIT = 10,                // cycles per delay step
    parameter STEP_SLOW  = 5,                 // cycles per slow step
    parameter STEP_FAST  = 1                  // cycles per fast step
) (
    input wire logic       clk_sys_in,        // system clock
    input wire logic       rst_in,            // sync reset, high
    input wire logic       ce_in,             // clock enable
    input wire logic       wr_en_in,          // write strobe
    input wire logic [7:0] addr_in,           // register address
    input wire logic [7:0] wr_data_in,        // write data
    input wire logic [7:0] rd_data_out,       // read data
    input wire logic [1:0] mode_in,           // playback mode
    input wire logic       start_in,          // start level
    input wire logic       library_ready_in,  // library loaded
    input wire logic       library_choice_out,// library choice
    input wire logic       sample_tick_out,   // step pulse
    input wire logic       slot_fetch_out,    // effect fetch pulse
    input wire logic [6:0] slot_effect_out,   // effect id
    input wire logic [7:0] drive_out,         // drive value
    input wire logic       drive_valid_out,   // drive live
    input wire logic       busy_out           // process running
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       seen_ready_r; // loaded flag may be up from here on
    logic [7:0] amp_r;        // mirror of the amplitude register
    // mirrors kept apart from the design so a stuck register shows up
    always @(posedge clk_sys_in) begin
        seen_ready_r <= rst_in ? 1'b0 : seen_ready_r | (ce_in & library_ready_in);
        if (rst_in) amp_r <= 8'h7f;
        else if (ce_in && wr_en_in && addr_in == 8'h0e) amp_r <= wr_data_in;
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    reset_values_a: assert property ($fell(rst_in) |-> !library_choice_out &&
        slot_effect_out == 7'h01 && !busy_out && !drive_valid_out) else $error("reset outputs");
    amp_readback_a: assert property (ce_in && wr_en_in && addr_in == 8'h0e ##1
        ce_in && !wr_en_in && addr_in == 8'h0e |=> rd_data_out == $past(wr_data_in, 2))
        else $error("amplitude read back");
    loaded_flag_a: assert property (ce_in && addr_in == 8'h0d && !seen_ready_r &&
        !library_ready_in |=> !rd_data_out[7]) else $error("loaded flag set early");
    choice_out_a: assert property (ce_in && wr_en_in && addr_in == 8'h0d |=>
        library_choice_out == $past(wr_data_in[6])) else $error("library choice");
    slot_effect_a: assert property (ce_in && wr_en_in && addr_in == 8'h0f |=>
        slot_effect_out == $past(wr_data_in[6:0])) else $error("slot effect id");
    direct_start_a: assert property (ce_in && mode_in == 2'h1 && start_in &&
        !busy_out && !drive_valid_out |=> busy_out) else $error("direct start");
    direct_follow_a: assert property ((ce_in && busy_out && mode_in == 2'h1 &&
        start_in && !wr_en_in)[*4] |-> drive_valid_out && drive_out == amp_r)
        else $error("direct drive value");
    direct_stop_a: assert property ($fell(busy_out) && mode_in == 2'h1 |=>
        !drive_valid_out) else $error("drive left live");
    tick_busy_a: assert property (sample_tick_out |-> busy_out || $past(busy_out))
        else $error("step outside playback");
    fetch_id_a: assert property (slot_fetch_out |-> slot_effect_out != 7'h00)
        else $error("fetch of stop id");
endmodule
bind haptic_playback_config_regs haptic_playback_monitor #(.DELAY_UNIT(DELAY_UNIT),
    .STEP_SLOW(STEP_SLOW), .STEP_FAST(STEP_FAST)) i_mon (.*);
`default_nettype wire

// ---- host_model.sv ----
`default_nettype none
module host_model (
    input  wire logic       clk_sys_in,   // system clock
    input  wire logic [7:0] rd_data_in,   // read data from device
    output var  logic       wr_en_out,    // write strobe
    output var  logic [7:0] addr_out,     // address
    output var  logic [7:0] wr_data_out   // write data
);
    timeunit 1ns;
    timeprecision 100ps;
    // bus quiet at time zero
    initial begin
        wr_en_out = 1'b0;
        addr_out = 8'h00;
        wr_data_out = 8'h00;
    end
    // one byte per strobe; released data goes to the inverse, never holds
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        wr_en_out <= 1'b1;
        addr_out <= a;
        wr_data_out <= d;
        @(posedge clk_sys_in);
        wr_en_out <= 1'b0;
        wr_data_out <= ~d;
    endtask
    // read answer lands one edge after the address is taken
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        addr_out <= a;
        @(posedge clk_sys_in);
        #1;
        d = rd_data_in;
    endtask
endmodule
`default_nettype wire

// ---- interval_timer.v ----
`default_nettype none
// counts a number of clock cycles then pulses done
module interval_timer #(
    parameter WIDTH = 32                 // counter width
) (
    input  wire             clk_sys_in,  // system clock
    input  wire             rst_in,      // sync reset, high
    input  wire             ce_in,       // clock enable
    input  wire             start_in,    // load and run
    input  wire             stop_in,     // abandon count
    input  wire [WIDTH-1:0] cycles_in,   // cycles to count, at least 1
    output reg              busy_out,    // counting
    output reg              done_out     // one-cycle pulse at end
);
    reg [WIDTH-1:0] count_r;             // cycles left

    // stop beats start so a cancel is never overridden
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            count_r  <= {WIDTH{1'b0}};
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else if (ce_in) begin
            done_out <= 1'b0;
            if (stop_in) begin
                busy_out <= 1'b0;
            end else if (start_in) begin
                count_r  <= cycles_in;
                busy_out <= 1'b1;
            end else if (busy_out) begin
                if (count_r <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end else begin
                    count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire
